// *** hdl/ibhp_pkg.sv ***
// constants, types and reset state of the instrument bus handshake port
package ibhp_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int PA_W = 5;
  localparam int BYTE_W = 8;

  // register word addresses
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] REG_RX = 4'h2;
  localparam logic [ADDR_W-1:0] REG_TX = 4'h3;
  localparam logic [ADDR_W-1:0] REG_SPOLL = 4'h4;

  // field positions
  localparam int CTRL_SRQ = 5;
  localparam int ST_LISTEN = 0;
  localparam int ST_TALK = 1;
  localparam int ST_REMOTE = 2;
  localparam int ST_LOCKOUT = 3;
  localparam int ST_SPOLL = 4;
  localparam int ST_RX_VALID = 5;
  localparam int ST_TX_BUSY = 6;
  localparam int ST_CLR_EVT = 7;
  localparam int XFER_EOI = 8;
  localparam int SP_RQS = 6;

  // multiline command codes, parity bit excluded
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;

  // level that an asserted open-drain line is pulled to
  localparam logic PIN_ASSERT = 1'b0;
  localparam logic [PA_W-1:0] PA_RESET = 5'h00;

  typedef enum logic [2:0] {ACC_IDLE = 3'b001, ACC_READY = 3'b010, ACC_TAKEN = 3'b100} ibhp_acc_e;
  typedef enum logic [2:0] {SRC_IDLE = 3'b001, SRC_WAIT = 3'b010, SRC_VALID = 3'b100} ibhp_src_e;

  typedef struct packed {
    logic [PA_W-1:0] pa;
    logic srq_pend;
    logic listen;
    logic talk;
    logic remote;
    logic lockout;
    logic spoll;
    logic sp_sent;
    logic clr_evt;
    logic rx_valid;
    logic [BYTE_W-1:0] rx_byte;
    logic rx_eoi;
    logic tx_pend;
    logic [BYTE_W-1:0] tx_byte;
    logic tx_eoi;
    logic [BYTE_W-1:0] sp_byte;
    logic [BYTE_W-1:0] dout_n;
    logic eoi_drv;
    ibhp_acc_e acc;
    ibhp_src_e src;
    logic [DATA_W-1:0] rd_data;
  } ibhp_state_s;

  localparam ibhp_state_s ST_RESET = '{
    pa: PA_RESET, srq_pend: 1'b0, listen: 1'b0, talk: 1'b0, remote: 1'b0, lockout: 1'b0,
    spoll: 1'b0, sp_sent: 1'b0, clr_evt: 1'b0, rx_valid: 1'b0, rx_byte: 8'h00, rx_eoi: 1'b0,
    tx_pend: 1'b0, tx_byte: 8'h00, tx_eoi: 1'b0, sp_byte: 8'h00, dout_n: 8'hFF, eoi_drv: 1'b0,
    acc: ACC_IDLE, src: SRC_IDLE, rd_data: 16'h0000};
endpackage : ibhp_pkg

// *** hdl/ibhp_reset_sync.sv ***
// reset release synchroniser
`timescale 1ns/100ps
`default_nettype none
module ibhp_reset_sync (
  input wire logic clk,
  input wire logic resetn,
  output logic rst_n
);
  logic stage1;
  logic stage2;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      stage2 <= stage1;
    end
  end

  assign rst_n = stage2;
endmodule : ibhp_reset_sync
`default_nettype wire

// *** hdl/ibhp_cmd_decode.sv ***
// classification of a byte taken while attention is asserted
`timescale 1ns/100ps
`default_nettype none
module ibhp_cmd_decode
  import ibhp_pkg::*;
(
  input wire logic [BYTE_W-1:0] bus_byte,
  input wire logic [PA_W-1:0] pa,
  output logic is_mla,
  output logic is_mta,
  output logic is_ota,
  output logic is_unl,
  output logic is_unt,
  output logic is_gtl,
  output logic is_sdc,
  output logic is_llo,
  output logic is_dcl,
  output logic is_spe,
  output logic is_spd
);
  logic [6:0] code;
  logic [1:0] grp;

  assign code = bus_byte[6:0];
  assign grp = code[6:5];
  assign is_unl = code == CMD_UNL;
  assign is_unt = code == CMD_UNT;
  assign is_mla = grp == GRP_LISTEN && code[PA_W-1:0] == pa && !is_unl;
  assign is_mta = grp == GRP_TALK && code[PA_W-1:0] == pa && !is_unt;
  assign is_ota = grp == GRP_TALK && code[PA_W-1:0] != pa && !is_unt;
  assign is_gtl = code == CMD_GTL;
  assign is_sdc = code == CMD_SDC;
  assign is_llo = code == CMD_LLO;
  assign is_dcl = code == CMD_DCL;
  assign is_spe = code == CMD_SPE;
  assign is_spd = code == CMD_SPD;
endmodule : ibhp_cmd_decode
`default_nettype wire

// *** hdl/ibhp_port.sv ***
// instrument bus handshake port: acceptor, source, command decode and registers
`timescale 1ns/100ps
`default_nettype none
// Operation
// - all bus lines are low true
// - whole bytes over eight data lines
// - attention bytes are addresses or commands
// - other bytes are data for addressed devices
// - interface clear drops talk and listen
// - remote enable permits remote mode
// - end line marks and detects last byte
// - service request asserted only when needed
// - fully interlocked handshake, no fixed timing
// - only the source drives data valid
// - hold not-ready until byte can be taken
// - hold not-accepted until byte is taken
// - source waits for ready and not-accepted
// - source asserts data valid when ready
// - acceptors assert not-ready and release not-accepted in the same cycle
// - same handshake for every kind of byte
// - device clear restores defaults
// - selective clear restores defaults when listening
// - go-to-local leaves remote when addressed
// - serial poll enable and disable
// - unlisten and untalk drop roles
// - listen and talk addresses from primary
// - no secondary addressing
// - release valid; then ready for next
// - addressed commands need own listen address
module ibhp_port
  import ibhp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [BYTE_W-1:0] dio_n_i,
  output logic [BYTE_W-1:0] dio_n_o,
  output logic dio_oe,
  input wire logic atn_n_i,
  input wire logic ifc_n_i,
  input wire logic ren_n_i,
  input wire logic eoi_n_i,
  output logic eoi_n_o,
  output logic eoi_oe,
  output logic srq_n_o,
  output logic srq_oe,
  input wire logic dav_n_i,
  output logic dav_n_o,
  output logic dav_oe,
  input wire logic nrfd_n_i,
  output logic nrfd_n_o,
  output logic nrfd_oe,
  input wire logic ndac_n_i,
  output logic ndac_n_o,
  output logic ndac_oe
);
  ibhp_state_s q;
  ibhp_state_s n;
  logic rst_n;
  logic [BYTE_W-1:0] bus_byte;
  logic acc_active;
  logic talk_active;
  logic rx_hold;
  logic take_cmd;
  logic dev_clr;
  logic [BYTE_W-1:0] poll_byte;
  logic dec_mla;
  logic dec_mta;
  logic dec_ota;
  logic dec_unl;
  logic dec_unt;
  logic dec_gtl;
  logic dec_sdc;
  logic dec_llo;
  logic dec_dcl;
  logic dec_spe;
  logic dec_spd;

  ibhp_reset_sync u_reset_sync (
    .clk(clk),
    .resetn(resetn),
    .rst_n(rst_n)
  );

  // low-true data lines read as true bits
  assign bus_byte = ~dio_n_i;

  ibhp_cmd_decode u_cmd_decode (
    .bus_byte(bus_byte),
    .pa(q.pa),
    .is_mla(dec_mla),
    .is_mta(dec_mta),
    .is_ota(dec_ota),
    .is_unl(dec_unl),
    .is_unt(dec_unt),
    .is_gtl(dec_gtl),
    .is_sdc(dec_sdc),
    .is_llo(dec_llo),
    .is_dcl(dec_dcl),
    .is_spe(dec_spe),
    .is_spd(dec_spd)
  );

  always_comb begin
    n = q;
    n.rd_data = '0;
    take_cmd = 1'b0;
    dev_clr = 1'b0;
    // every device accepts under attention; data only while listening
    acc_active = !atn_n_i || (q.listen && !q.talk);
    talk_active = q.talk && atn_n_i;
    rx_hold = atn_n_i && q.rx_valid;
    poll_byte = q.sp_byte;
    poll_byte[SP_RQS] = q.srq_pend;

    // source side; hardware clears come before software writes
    case (q.src)
      SRC_IDLE: begin
        // status byte replaces output while polled
        if (talk_active && (q.spoll ? !q.sp_sent : q.tx_pend)) begin
          n.dout_n = q.spoll ? ~poll_byte : ~q.tx_byte;
          n.eoi_drv = q.spoll ? 1'b0 : q.tx_eoi;
          n.src = SRC_WAIT;
        end
      end
      SRC_WAIT: begin
        // no timer: wait for ready and not-accepted
        if (!talk_active) begin
          n.src = SRC_IDLE;
        end else if (nrfd_n_i && !ndac_n_i) begin
          n.src = SRC_VALID;
        end
      end
      SRC_VALID: begin
        if (!talk_active) begin
          n.src = SRC_IDLE;
        end else if (ndac_n_i) begin
          n.src = SRC_IDLE;
          if (q.spoll) begin
            n.sp_sent = 1'b1;
            n.srq_pend = 1'b0;
          end else begin
            n.tx_pend = 1'b0;
          end
        end
      end
      default: n.src = SRC_IDLE;
    endcase
    if (!q.spoll || !q.talk) begin
      n.sp_sent = 1'b0;
    end

    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: n.rd_data = DATA_W'({q.srq_pend, q.pa});
        REG_STATUS: n.rd_data = DATA_W'({q.clr_evt, q.tx_pend, q.rx_valid, q.spoll,
                                         q.lockout, q.remote, q.talk, q.listen});
        REG_RX: n.rd_data = DATA_W'({q.rx_eoi, q.rx_byte});
        REG_TX: n.rd_data = DATA_W'({q.tx_eoi, q.tx_byte});
        REG_SPOLL: n.rd_data = DATA_W'(q.sp_byte);
        default: n.rd_data = '0;
      endcase
      if (reg_addr == REG_RX) begin
        n.rx_valid = 1'b0;
      end
    end

    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: begin
          n.pa = reg_wdata[PA_W-1:0];
          n.srq_pend = reg_wdata[CTRL_SRQ];
        end
        REG_STATUS: begin
          if (reg_wdata[ST_CLR_EVT]) begin
            n.clr_evt = 1'b0;
          end
        end
        REG_TX: begin
          if (!q.tx_pend) begin
            n.tx_byte = reg_wdata[BYTE_W-1:0];
            n.tx_eoi = reg_wdata[XFER_EOI];
            n.tx_pend = 1'b1;
          end
        end
        REG_SPOLL: n.sp_byte = reg_wdata[BYTE_W-1:0];
        default: n.pa = q.pa;
      endcase
    end

    // one acceptor sequence for commands, addresses and data
    case (q.acc)
      ACC_IDLE: begin
        if (acc_active) begin
          n.acc = ACC_READY;
        end
      end
      ACC_READY: begin
        if (!acc_active) begin
          n.acc = ACC_IDLE;
        end else if (!dav_n_i && !rx_hold) begin
          // byte seen: assert not-ready, release not-accepted
          n.acc = ACC_TAKEN;
          if (!atn_n_i) begin
            // attention byte goes to the decoder
            take_cmd = 1'b1;
          end else begin
            n.rx_byte = bus_byte;
            // end line tags the last byte
            n.rx_eoi = !eoi_n_i;
            n.rx_valid = 1'b1;
          end
        end
      end
      ACC_TAKEN: begin
        // valid released; ready for the next byte
        if (dav_n_i) begin
          n.acc = acc_active ? ACC_READY : ACC_IDLE;
        end
      end
      default: n.acc = ACC_IDLE;
    endcase

    if (take_cmd) begin
      if (dec_mla) begin
        n.listen = 1'b1;
        n.remote = n.remote || !ren_n_i;
      end
      if (dec_mta) begin
        n.talk = 1'b1;
      end
      if (dec_unl) begin
        n.listen = 1'b0;
      end
      if (dec_unt || dec_ota) begin
        n.talk = 1'b0;
      end
      if (dec_gtl && q.listen) begin
        n.remote = 1'b0;
      end
      if (dec_llo) begin
        n.lockout = 1'b1;
      end
      // serial poll mode on and off
      if (dec_spe) begin
        n.spoll = 1'b1;
      end
      if (dec_spd) begin
        n.spoll = 1'b0;
      end
      // universal clear; selective only when listening
      dev_clr = dec_dcl || (dec_sdc && q.listen);
      if (dev_clr) begin
        n.clr_evt = 1'b1;
        n.rx_valid = 1'b0;
        n.tx_pend = 1'b0;
      end
    end

    // remote only while remote enable is asserted
    if (ren_n_i) begin
      n.remote = 1'b0;
      n.lockout = 1'b0;
    end

    // interface clear empties roles and handshakes
    if (!ifc_n_i) begin
      n.listen = 1'b0;
      n.talk = 1'b0;
      n.spoll = 1'b0;
      n.sp_sent = 1'b0;
      n.acc = ACC_IDLE;
      n.src = SRC_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= ST_RESET;
    end else begin
      q <= n;
    end
  end

  // open-drain lines pull low when enabled
  assign dio_n_o = q.dout_n;
  assign dio_oe = q.src != SRC_IDLE;
  // data valid comes only from the source machine
  assign dav_oe = q.src == SRC_VALID;
  // end line asserted together with data valid
  assign eoi_oe = dav_oe && q.eoi_drv;
  // not-ready held after a byte is taken, and while ready with a data byte unread and attention released
  assign nrfd_oe = (q.acc == ACC_READY && rx_hold) || q.acc == ACC_TAKEN;
  // not-accepted held until the byte is taken
  assign ndac_oe = q.acc == ACC_READY;
  assign srq_oe = q.srq_pend;
  assign dav_n_o = PIN_ASSERT;
  assign eoi_n_o = PIN_ASSERT;
  assign nrfd_n_o = PIN_ASSERT;
  assign ndac_n_o = PIN_ASSERT;
  assign srq_n_o = PIN_ASSERT;
  assign reg_rdata = q.rd_data;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_dav_seen;
    q.acc == ACC_READY && !dav_n_i && !nrfd_oe && ifc_n_i && acc_active;
  endsequence

  sequence s_all_accepted;
    dav_oe && ndac_n_i && atn_n_i && ifc_n_i;
  endsequence

  chk_ifc_clear_roles: assert property (!ifc_n_i |=> !q.listen && !q.talk)
    else $error("roles kept after interface clear");

  // valid only after ready and not-accepted were seen
  chk_dav_after_ready: assert property ($rose(dav_oe) |-> $past(nrfd_n_i) && !$past(ndac_n_i))
    else $error("data valid asserted before acceptors ready");

  // only a talker drives data valid
  chk_dav_only_talker: assert property (dav_oe |-> q.talk && dio_oe)
    else $error("data valid driven while not talking");

  // an unread byte is never overwritten
  chk_rx_not_overrun: assert property (q.rx_valid && !reg_rd && atn_n_i |=> $stable(q.rx_byte))
    else $error("receive byte overwritten while held");

  // byte taken: not-accepted released, not-ready asserted
  chk_ndac_taken: assert property (s_dav_seen |=> !ndac_oe && nrfd_oe)
    else $error("acceptor handshake wrong after data valid");

  // valid released once every acceptor took the byte
  chk_dav_released: assert property (s_all_accepted |=> !dav_oe ##1 !dav_oe)
    else $error("data valid held after acceptance");

  // ready again once valid released under attention
  chk_ready_next: assert property (q.acc == ACC_TAKEN && dav_n_i && !atn_n_i && ifc_n_i
    |=> ndac_oe && (atn_n_i || !nrfd_oe))
    else $error("acceptor not ready for next byte");

  // service request follows the software request
  chk_srq_request: assert property (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_SRQ] |=> srq_oe)
    else $error("service request not asserted");

  // remote mode left when remote enable drops
  chk_ren_local: assert property (ren_n_i |=> !q.remote)
    else $error("remote kept without remote enable");

  // device clear raises the clear event
  chk_dcl_event: assert property (take_cmd && dec_dcl |=> q.clr_evt && !q.rx_valid)
    else $error("device clear not taken");

  // selective clear ignored when not listening
  chk_sdc_addressed: assert property (take_cmd && dec_sdc && !q.listen && !q.clr_evt |=> !q.clr_evt)
    else $error("selective clear acted on while not addressed");

  chk_unl_leave: assert property (take_cmd && dec_unl && ifc_n_i |=> !q.listen)
    else $error("listener role kept after unlisten");

  // end line only beside data valid of a message byte
  chk_eoi_with_dav: assert property (eoi_oe |-> dav_oe && q.tx_pend && q.tx_eoi && !q.spoll)
    else $error("end line asserted outside a valid byte");
endmodule : ibhp_port
`default_nettype wire

// *** testbench/ibhp_ctrl_model.sv ***
// bus controller model: source and acceptor on the far side
`timescale 1ns/100ps
`default_nettype none
module ibhp_ctrl_model (
  input wire logic clk,
  input wire logic [7:0] dio_w,
  input wire logic dav_w,
  input wire logic nrfd_w,
  input wire logic ndac_w,
  input wire logic eoi_w,
  output logic atn_n,
  output logic ifc_n,
  output logic ren_n,
  output logic [7:0] m_dio,
  output logic m_dav,
  output logic m_nrfd,
  output logic m_ndac,
  output logic m_eoi
);
  int stalls = 0;
  initial begin
    {atn_n, ifc_n, ren_n} = 3'h7;
    {m_dio, m_dav, m_nrfd, m_ndac, m_eoi} = '0;
  end
  task automatic lines(input logic ifc, input logic ren);
    @(posedge clk);
    ifc_n <= ~ifc;
    ren_n <= ~ren;
  endtask : lines
  task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
    int n;
    @(posedge clk);
    atn_n <= ~atn;
    m_dio <= b;
    m_eoi <= eoi;
    m_nrfd <= 1'b0;
    m_ndac <= 1'b0;
    repeat (13) @(posedge clk);
    // wait for ready and not accepted
    for (n = 0; n < 400 && !(nrfd_w && !ndac_w); n++) @(posedge clk);
    if (n == 400) stalls++;
    m_dav <= 1'b1;
    for (n = 0; n < 400 && !ndac_w; n++) @(posedge clk);
    m_dav <= 1'b0;
    m_dio <= 8'h00;
    m_eoi <= 1'b0;
    if (n == 400) stalls++;
  endtask : send
  // acceptor for bytes the device talks
  task automatic recv(output logic [7:0] b, output logic eoi);
    int n;
    @(posedge clk);
    atn_n <= 1'b1;
    m_ndac <= 1'b1;
    m_nrfd <= 1'b0;
    for (n = 0; n < 400 && dav_w; n++) @(posedge clk);
    if (n == 400) stalls++;
    b = ~dio_w;
    eoi = ~eoi_w;
    m_nrfd <= 1'b1;
    m_ndac <= 1'b0;
    for (n = 0; n < 400 && !dav_w; n++) @(posedge clk);
    m_nrfd <= 1'b0;
    m_ndac <= 1'b1;
    if (n == 400) stalls++;
  endtask : recv
endmodule : ibhp_ctrl_model
`default_nettype wire

// *** testbench/ibhp_port_tb.sv ***
// self-checking bench of the instrument bus handshake port
`timescale 1ns/100ps
`default_nettype none
module ibhp_port_tb;
  import ibhp_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata, s;
  logic [BYTE_W-1:0] dio_n_o, m_dio, dio_w, gb, sp;
  logic dio_oe, eoi_n_o, eoi_oe, srq_n_o, srq_oe, dav_n_o, dav_oe, nrfd_n_o, nrfd_oe, ndac_n_o, ndac_oe;
  logic atn_n, ifc_n, ren_n, m_dav, m_nrfd, m_ndac, m_eoi, dav_w, nrfd_w, ndac_w, eoi_w, ge;
  int miscompares = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h95c3d9a0;
  logic [31:0] r;
  logic [PA_W-1:0] pa;
  // wired lines: low if any party pulls, pull-up otherwise
  assign dio_w = ~((dio_oe ? ~dio_n_o : 8'h00) | m_dio);
  assign dav_w = ~((dav_oe & ~dav_n_o) | m_dav);
  assign nrfd_w = ~((nrfd_oe & ~nrfd_n_o) | m_nrfd);
  assign ndac_w = ~((ndac_oe & ~ndac_n_o) | m_ndac);
  assign eoi_w = ~((eoi_oe & ~eoi_n_o) | m_eoi);
  initial forever #4 clk = ~clk;
  ibhp_port i_dut (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dio_n_i(dio_w), .dio_n_o(dio_n_o), .dio_oe(dio_oe),
    .atn_n_i(atn_n), .ifc_n_i(ifc_n), .ren_n_i(ren_n),
    .eoi_n_i(eoi_w), .eoi_n_o(eoi_n_o), .eoi_oe(eoi_oe),
    .srq_n_o(srq_n_o), .srq_oe(srq_oe),
    .dav_n_i(dav_w), .dav_n_o(dav_n_o), .dav_oe(dav_oe),
    .nrfd_n_i(nrfd_w), .nrfd_n_o(nrfd_n_o), .nrfd_oe(nrfd_oe),
    .ndac_n_i(ndac_w), .ndac_n_o(ndac_n_o), .ndac_oe(ndac_oe)
  );
  ibhp_ctrl_model i_ctrl (
    .clk(clk), .dio_w(dio_w), .dav_w(dav_w), .nrfd_w(nrfd_w), .ndac_w(ndac_w),
    .eoi_w(eoi_w), .atn_n(atn_n), .ifc_n(ifc_n), .ren_n(ren_n), .m_dio(m_dio),
    .m_dav(m_dav), .m_nrfd(m_nrfd), .m_ndac(m_ndac), .m_eoi(m_eoi)
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] addr_of(input logic [1:0] grp);
    return {1'b0, grp, pa};
  endfunction : addr_of
  function automatic logic [7:0] poll_of(input logic [7:0] v, input logic rqs);
    logic [7:0] t;
    t = v;
    t[SP_RQS] = rqs;
    return t;
  endfunction : poll_of
  task automatic check(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic cmd_chk(input logic [7:0] c, input int k, input logic e);
    i_ctrl.send(c, 1'b1, 1'b0);
    rd(REG_STATUS, s);
    check($sformatf("status bit %0d", k), 16'(e), 16'(s[k]));
    wr(REG_STATUS, 16'h0080);
  endtask : cmd_chk
  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    check("oe after reset", 16'h0000, 16'({dio_oe, eoi_oe, srq_oe, dav_oe, nrfd_oe, ndac_oe}));
    rd(REG_STATUS, s);
    check("status after reset", 16'h0000, s);
    rd(4'hF, s);
    check("unmapped read", 16'h0000, s);
    $display("test reset done");
    r = rnd();
    pa = PA_W'(r % 31);
    wr(REG_CTRL, 16'(pa));
    i_ctrl.lines(1'b0, 1'b1);
    i_ctrl.send(addr_of(GRP_LISTEN), 1'b1, 1'b0);
    rd(REG_STATUS, s);
    check("listen", 16'h0001, 16'(s[ST_LISTEN]));
    check("remote", 16'h0001, 16'(s[ST_REMOTE]));
    $display("test address done");
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      i_ctrl.send(r[7:0], 1'b0, i == 3);
      // let the acceptor return to ready with the byte still unread
      repeat (2) @(posedge clk);
      check("hold not ready", 16'h0001, 16'(nrfd_oe));
      rd(REG_RX, s);
      check("rx word", {7'h00, i == 3, r[7:0]}, s);
    end
    $display("test listen done");
    cmd_chk({1'b0, CMD_GTL}, ST_REMOTE, 1'b0);
    cmd_chk({1'b0, CMD_LLO}, ST_LOCKOUT, 1'b1);
    cmd_chk({1'b0, CMD_DCL}, ST_CLR_EVT, 1'b1);
    cmd_chk({1'b1, CMD_SDC}, ST_CLR_EVT, 1'b1);
    cmd_chk({1'b0, CMD_UNL}, ST_LISTEN, 1'b0);
    cmd_chk(addr_of(2'h3), ST_LISTEN, 1'b0);
    cmd_chk({1'b0, CMD_SDC}, ST_CLR_EVT, 1'b0);
    cmd_chk(addr_of(GRP_TALK), ST_TALK, 1'b1);
    cmd_chk({1'b0, CMD_UNT}, ST_TALK, 1'b0);
    cmd_chk(addr_of(GRP_TALK), ST_TALK, 1'b1);
    cmd_chk({1'b0, GRP_TALK, pa ^ 5'h01}, ST_TALK, 1'b0);
    cmd_chk(addr_of(GRP_TALK), ST_TALK, 1'b1);
    $display("test commands done");
    for (int i = 0; i < 2; i++) begin
      r = rnd();
      wr(REG_TX, {7'h00, i == 1, r[7:0]});
      i_ctrl.recv(gb, ge);
      check("talk byte", 16'(r[7:0]), 16'(gb));
      check("talk end", 16'(i == 1), 16'(ge));
    end
    rd(REG_STATUS, s);
    check("tx busy", 16'h0000, 16'(s[ST_TX_BUSY]));
    $display("test talk done");
    r = rnd();
    sp = r[7:0];
    wr(REG_SPOLL, 16'(sp));
    wr(REG_CTRL, 16'(pa) | (16'h0001 << CTRL_SRQ));
    repeat (2) @(posedge clk);
    check("srq set", 16'h0001, 16'(srq_oe));
    cmd_chk({1'b0, CMD_SPE}, ST_SPOLL, 1'b1);
    i_ctrl.recv(gb, ge);
    check("poll byte", 16'(poll_of(sp, 1'b1)), 16'(gb));
    repeat (2) @(posedge clk);
    check("srq clear", 16'h0000, 16'(srq_oe));
    cmd_chk({1'b0, CMD_SPD}, ST_SPOLL, 1'b0);
    $display("test poll done");
    i_ctrl.send(addr_of(GRP_LISTEN), 1'b1, 1'b0);
    rd(REG_STATUS, s);
    check("roles set", 16'h0007, 16'(s[2:0]));
    i_ctrl.lines(1'b0, 1'b0);
    repeat (2) @(posedge clk);
    rd(REG_STATUS, s);
    check("remote off", 16'h0000, 16'(s[ST_LOCKOUT:ST_REMOTE]));
    i_ctrl.lines(1'b1, 1'b0);
    repeat (2) @(posedge clk);
    i_ctrl.lines(1'b0, 1'b0);
    rd(REG_STATUS, s);
    check("roles after clear", 16'h0000, 16'(s[1:0]));
    check("model stalls", 16'h0000, 16'(i_ctrl.stalls));
    $display("test clear done");
    test_done();
  end
endmodule : ibhp_port_tb
`default_nettype wire
